/* rtl/ppfo_regs.svh */
// constants of the printer-port frame output engine
`ifndef PPFO_REGS_SVH
`define PPFO_REGS_SVH
// ----------------------------------------------------------------------
// frame and character codes
// ----------------------------------------------------------------------
`define PPFO_FRAME_LEN    40
`define PPFO_EOL_CODE     8'h9B
`define PPFO_CR_CODE      8'h0D
`define PPFO_BLANK_CODE   8'h20
// ----------------------------------------------------------------------
// status codes
// ----------------------------------------------------------------------
`define PPFO_ST_OK        8'h80
`define PPFO_ST_BADCMD    8'h81
`define PPFO_ST_BADFRM    8'h82
`define PPFO_ST_TIMEOUT   8'h84
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PPFO_CLK_MHZ      100
`define PPFO_TIMEOUT_S    4
`define PPFO_TIMEOUT_CYC  (`PPFO_TIMEOUT_S * `PPFO_CLK_MHZ * 1000000)
`define PPFO_SETUP_NS     1000
`define PPFO_SETUP_CYC    ((`PPFO_SETUP_NS * `PPFO_CLK_MHZ + 999) / 1000)
`define PPFO_STROBE_NS    1000
`define PPFO_STROBE_CYC   ((`PPFO_STROBE_NS * `PPFO_CLK_MHZ + 999) / 1000)
`endif

/* rtl/ppfo_pkg.sv */
// types shared by the printer-port frame output engine
package ppfo_pkg;
   // ----------------------------------------------------------------------
   // host command and answer
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {OP_WRITE, OP_STATUS, OP_OTHER} ppfo_op_type;
   typedef struct packed {
      ppfo_op_type op;
   } ppfo_cmd_type;
   typedef struct packed {
      logic [7:0] status;
   } ppfo_rsp_type;
   // ----------------------------------------------------------------------
   // printer side
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] data;
      logic       strobe_n;
   } ppfo_prn_out_type;
   typedef enum {ST_IDLE, ST_RECV, ST_SETUP, ST_STROBE, ST_WAIT, ST_RESP} ppfo_state_type;
endpackage

/* rtl/ppfo_byte_xlate.sv */
// end-of-line substitution for one outgoing byte
`timescale 1ns/1ps
`include "ppfo_regs.svh"
module ppfo_byte_xlate (
   input  wire logic [7:0] raw_byte,
   input  wire logic       prev_cr,
   output logic      [7:0] out_byte,
   output logic            is_eol,
   output logic            emits_cr
);
   // ----------------------------------------------------------------------
   // translation
   // ----------------------------------------------------------------------
   // only end-of-line is touched; back-to-back ones alternate cr/blank
   always_comb begin
      is_eol   = (raw_byte == `PPFO_EOL_CODE);
      emits_cr = is_eol && !prev_cr;
      if (!is_eol) begin
         out_byte = raw_byte;
      end else if (emits_cr) begin
         out_byte = `PPFO_CR_CODE;
      end else begin
         out_byte = `PPFO_BLANK_CODE;
      end
   end
endmodule

/* rtl/ppfo_frame_output.sv */
// printer-port frame output engine: frame intake, translation, strobe, status
//
// Summary of operation
// - commands served only with printer attached
// - frame bytes forwarded one by one, in order
// - bytes after first end-of-line are dropped
// - end-of-line becomes carriage return 13
// - all other bytes pass unchanged, bit 7
// - no line feed added after return
// - repeated end-of-lines alternate return and blank
// - frame without end-of-line sent whole
// - status 128 ok, 129, 130, 132
// - status answered only when printer powered
`timescale 1ns/1ps
`include "ppfo_regs.svh"
module ppfo_frame_output
   import ppfo_pkg::*;
#(
   parameter int unsigned FRAME_LEN   = `PPFO_FRAME_LEN,
   parameter int unsigned TIMEOUT_CYC = `PPFO_TIMEOUT_CYC
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             cmd_valid,
   input  wire ppfo_cmd_type     cmd,
   output logic                  cmd_ready,
   input  wire logic             fb_valid,
   input  wire logic [7:0]       fb_data,
   input  wire logic             fb_err,
   output logic                  fb_ready,
   output logic                  rsp_valid,
   output ppfo_rsp_type          rsp,
   input  wire logic             prn_present,
   input  wire logic             prn_online,
   input  wire logic             prn_busy,
   input  wire logic             prn_ack_n,
   output ppfo_prn_out_type      prn
);
   localparam int IW = $clog2(FRAME_LEN);
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   localparam int CW = 8;

   ppfo_state_type st_q;
   logic [IW-1:0]  idx_q;
   logic [CW-1:0]  cnt_q;
   logic [TW-1:0]  tmr_q;
   logic [7:0]     status_q;
   logic [7:0]     data_q;
   logic           err_q;
   logic           last_cr_q;
   logic [7:0]     mem_q [FRAME_LEN];
   logic [7:0]     xl_byte;
   logic           xl_eol;
   logic           xl_cr;
   logic           cmd_take;
   logic           fb_take;
   logic           frame_in;
   logic           sending;
   logic           tmo;
   logic           byte_done;
   logic           last_byte;

   // ----------------------------------------------------------------------
   // byte translation
   // ----------------------------------------------------------------------
   ppfo_byte_xlate u_xlate (
      .raw_byte (mem_q[idx_q]),
      .prev_cr  (last_cr_q),
      .out_byte (xl_byte),
      .is_eol   (xl_eol),
      .emits_cr (xl_cr)
   );

   // ----------------------------------------------------------------------
   // handshakes and sequencing terms
   // ----------------------------------------------------------------------
   // an absent printer means silence, not an error answer
   assign cmd_ready = (st_q == ST_IDLE) && prn_present
                      && ((cmd.op != OP_STATUS) || prn_online);
   assign cmd_take  = cmd_valid && cmd_ready;
   assign fb_ready  = (st_q == ST_RECV);
   assign fb_take   = fb_valid && fb_ready;
   assign frame_in  = fb_take && (idx_q == IW'(FRAME_LEN - 1));
   assign sending   = (st_q == ST_SETUP) || (st_q == ST_STROBE) || (st_q == ST_WAIT);
   assign tmo       = sending && (tmr_q == TW'(TIMEOUT_CYC - 1));
   // either acknowledge pulse or busy released lets the next byte go
   assign byte_done = (st_q == ST_WAIT) && !tmo && (!prn_ack_n || !prn_busy);
   assign last_byte = xl_eol || (idx_q == IW'(FRAME_LEN - 1));
   assign rsp_valid = (st_q == ST_RESP);
   assign rsp.status = status_q;
   // one driver for the whole printer bundle
   assign prn = ppfo_prn_out_type'{data: data_q, strobe_n: (st_q != ST_STROBE)};

   // ----------------------------------------------------------------------
   // state machine
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (cmd_take) begin
                  st_q <= (cmd.op == OP_WRITE) ? ST_RECV : ST_RESP;
               end
            end
            ST_RECV: begin
               if (frame_in) begin
                  st_q <= (err_q || fb_err) ? ST_RESP : ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (tmo) begin
                  st_q <= ST_RESP;
               end else if (cnt_q == CW'(`PPFO_SETUP_CYC - 1)) begin
                  st_q <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               if (tmo) begin
                  st_q <= ST_RESP;
               end else if (cnt_q == CW'(`PPFO_STROBE_CYC - 1)) begin
                  st_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (tmo) begin
                  st_q <= ST_RESP;
               end else if (byte_done) begin
                  st_q <= last_byte ? ST_RESP : ST_SETUP;
               end
            end
            ST_RESP: st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // frame store and byte index
   // ----------------------------------------------------------------------
   // whole frame is held so a slow printer never stalls the host bus
   always_ff @(posedge sys_clk) begin
      if (fb_take) begin
         mem_q[idx_q] <= fb_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_q <= '0;
      end else if (cmd_take || frame_in) begin
         idx_q <= '0;
      end else if (fb_take || (byte_done && !last_byte)) begin
         idx_q <= idx_q + IW'(1);
      end
   end

   // bus error flag for the frame under intake
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         err_q <= 1'b0;
      end else if (cmd_take) begin
         err_q <= 1'b0;
      end else if (fb_take && fb_err) begin
         err_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // setup/strobe counter and frame timer
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if ((st_q == ST_SETUP && cnt_q == CW'(`PPFO_SETUP_CYC - 1))
                   || st_q == ST_WAIT || !sending) begin
         cnt_q <= '0;
      end else if (st_q == ST_STROBE && cnt_q == CW'(`PPFO_STROBE_CYC - 1)) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   // timer covers the whole frame, not each byte
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmr_q <= '0;
      end else if (!sending) begin
         tmr_q <= '0;
      end else begin
         tmr_q <= tmr_q + TW'(1);
      end
   end

   // ----------------------------------------------------------------------
   // printer data and alternation memory
   // ----------------------------------------------------------------------
   // data follows the index during setup and is frozen through the strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= 8'h00;
      end else if (st_q == ST_SETUP) begin
         data_q <= xl_byte;
      end
   end

   // kept across frames, since each frame sends one end-of-line at most
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_cr_q <= 1'b0;
      end else if (byte_done) begin
         last_cr_q <= xl_cr;
      end
   end

   // ----------------------------------------------------------------------
   // status code
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= `PPFO_ST_OK;
      end else if (cmd_take && cmd.op == OP_OTHER) begin
         status_q <= `PPFO_ST_BADCMD;
      end else if (frame_in && (err_q || fb_err)) begin
         status_q <= `PPFO_ST_BADFRM;
      end else if (tmo) begin
         status_q <= `PPFO_ST_TIMEOUT;
      end else if (byte_done && last_byte) begin
         status_q <= `PPFO_ST_OK;
      end
   end

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_cmd_gate;
      cmd_take |-> prn_present;
   endproperty
   a_cmd_gate: assert property (p_cmd_gate)
      else $error("command taken without printer");

   property p_stat_gate;
      cmd_take && cmd.op == OP_STATUS |-> prn_online ##1 rsp_valid;
   endproperty
   a_stat_gate: assert property (p_stat_gate)
      else $error("status answer wrong");

   property p_in_order;
      byte_done && !last_byte |=> st_q == ST_SETUP && idx_q == $past(idx_q) + IW'(1);
   endproperty
   a_in_order: assert property (p_in_order)
      else $error("byte order broken");

   property p_cut_eol;
      byte_done && xl_eol |=> rsp_valid && status_q == `PPFO_ST_OK;
   endproperty
   a_cut_eol: assert property (p_cut_eol)
      else $error("bytes after end-of-line sent");

   property p_cr_sub;
      st_q == ST_STROBE && xl_eol && !last_cr_q |-> prn.data == `PPFO_CR_CODE;
   endproperty
   a_cr_sub: assert property (p_cr_sub)
      else $error("end-of-line not turned into return");

   property p_pass;
      st_q == ST_STROBE && !xl_eol |-> prn.data == mem_q[idx_q];
   endproperty
   a_pass: assert property (p_pass)
      else $error("plain byte altered");

   property p_alt;
      st_q == ST_STROBE && xl_eol && last_cr_q |-> prn.data == `PPFO_BLANK_CODE;
   endproperty
   a_alt: assert property (p_alt)
      else $error("repeated end-of-line not blank");

   property p_timeout;
      tmo |=> rsp_valid && status_q == `PPFO_ST_TIMEOUT && prn.strobe_n;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("timeout not recorded");

   property p_strobe;
      $fell(prn.strobe_n) |-> $stable(prn.data) ##1 $stable(prn.data);
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("data moved around strobe");

   property p_badcmd;
      cmd_take && cmd.op == OP_OTHER |=> rsp_valid && rsp.status == `PPFO_ST_BADCMD;
   endproperty
   a_badcmd: assert property (p_badcmd)
      else $error("invalid command status wrong");
endmodule

/* verification/ppfo_printer_model.sv */
// behavioural parallel printer facing the frame output engine
`timescale 1ns/1ps
module ppfo_printer_model
   import ppfo_pkg::*;
#(
   parameter int HOLD_CYC = 5
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire ppfo_prn_out_type prn,
   input  wire logic             stall,
   output logic                  prn_busy,
   output logic                  prn_ack_n
);
   // ----------------------------------------------------------------------
   // strobe capture and busy/acknowledge handshake
   // ----------------------------------------------------------------------
   logic [7:0] got[$];
   logic       strobe_q;
   int         cnt_q;

   // busy rises with strobe and stays up past it, so the engine cannot run ahead
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prn_busy  <= 1'b0;
         prn_ack_n <= 1'b1;
         strobe_q  <= 1'b1;
         cnt_q     <= 0;
      end else begin
         strobe_q  <= prn.strobe_n;
         prn_ack_n <= 1'b1;
         if (!prn.strobe_n) begin
            prn_busy <= 1'b1;
            cnt_q    <= HOLD_CYC;
            if (strobe_q) got.push_back(prn.data);
         end else if (prn_busy && !stall) begin
            // stall stands in for a jammed printer, otherwise answer promptly
            if (cnt_q == 0) begin
               prn_busy  <= 1'b0;
               prn_ack_n <= 1'b0;
            end else begin
               cnt_q <= cnt_q - 1;
            end
         end
      end
   end
endmodule

/* verification/printer_port_frame_output_tb_top.sv */
// self-checking bench for the printer-port frame output engine
`timescale 1ns/1ps
`include "ppfo_regs.svh"
module printer_port_frame_output_tb_top;
   import ppfo_pkg::*;
   // ----------------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------------
   localparam int TO = 20000;
   logic             sys_clk = 1'b0;
   logic             rst_n = 1'b0;
   logic             cmd_valid = 1'b0;
   ppfo_cmd_type     cmd = '0;
   logic             cmd_ready, fb_ready, rsp_valid, prn_busy, prn_ack_n;
   logic             fb_valid = 1'b0;
   logic [7:0]       fb_data = 8'h00;
   logic             fb_err = 1'b0;
   ppfo_rsp_type     rsp;
   logic             prn_present = 1'b1;
   logic             prn_online = 1'b1;
   logic             stall = 1'b0;
   ppfo_prn_out_type prn;
   logic [7:0]       fr[40];
   logic [7:0]       e[$];
   int               n_fail = 0;
   int               total_checks = 0;

   always #5 sys_clk = ~sys_clk;

   ppfo_frame_output #(.FRAME_LEN(40), .TIMEOUT_CYC(TO)) ppfo_frame_output_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .fb_valid(fb_valid), .fb_data(fb_data), .fb_err(fb_err),
      .fb_ready(fb_ready), .rsp_valid(rsp_valid), .rsp(rsp), .prn_present(prn_present),
      .prn_online(prn_online), .prn_busy(prn_busy), .prn_ack_n(prn_ack_n), .prn(prn));
   ppfo_printer_model #(.HOLD_CYC(5)) ppfo_printer_model_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .prn(prn), .stall(stall),
      .prn_busy(prn_busy), .prn_ack_n(prn_ack_n));

   // ----------------------------------------------------------------------
   // shared tasks; all start and end at a falling edge
   // ----------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic do_cmd(input ppfo_op_type op);
      int i;
      cmd.op    = op;
      cmd_valid = 1'b1;
      for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge sys_clk);
      check({7'h0, cmd_ready}, 8'h01);
      @(negedge sys_clk);
      cmd_valid = 1'b0;
   endtask

   // answer pulse must stand exactly one cycle
   task automatic wait_rsp(input logic [7:0] exp, input int lim);
      int i;
      for (i = 0; i < lim && rsp_valid !== 1'b1; i++) @(negedge sys_clk);
      check({7'h0, rsp_valid}, 8'h01);
      check(rsp.status, exp);
      @(negedge sys_clk);
      check({7'h0, rsp_valid}, 8'h00);
   endtask

   // host side: always a whole 40-byte frame, padded where it ends early
   task automatic send_frame(input int err_at);
      int i, j;
      for (i = 0; i < 40; i++) begin
         fb_data  = fr[i];
         fb_err   = (i == err_at);
         fb_valid = 1'b1;
         for (j = 0; j < 50 && fb_ready !== 1'b1; j++) @(negedge sys_clk);
         check({6'h0, fb_ready, cmd_ready}, 8'h02);
         @(negedge sys_clk);
      end
      fb_valid = 1'b0;
      fb_err   = 1'b0;
      check({7'h0, fb_ready}, 8'h00);
   endtask

   task automatic check_got();
      check(8'(ppfo_printer_model_inst.got.size()), 8'(e.size()));
      foreach (e[k]) begin
         if (k < ppfo_printer_model_inst.got.size())
            check(ppfo_printer_model_inst.got[k], e[k]);
      end
      ppfo_printer_model_inst.got.delete();
      e.delete();
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic s_full();
      for (int i = 0; i < 40; i++) begin
         fr[i] = (i >= 35) ? 8'h20 : (i % 2) ? 8'hC0 + 8'(i) : 8'h41 + 8'(i);
         e.push_back(fr[i]);
      end
      do_cmd(OP_WRITE);
      send_frame(-1);
      wait_rsp(`PPFO_ST_OK, TO);
      check_got();
   endtask

   // three frames: text then end-of-lines, alternation spans frames
   task automatic s_eol();
      for (int f = 0; f < 3; f++) begin
         for (int i = 0; i < 40; i++) fr[i] = 8'h20;
         fr[0] = (f == 0) ? 8'h41 : `PPFO_EOL_CODE;
         fr[1] = `PPFO_EOL_CODE;
         fr[2] = 8'h42;
         if (f == 0) e = '{8'h41, `PPFO_CR_CODE};
         else e = '{(f == 1) ? `PPFO_BLANK_CODE : `PPFO_CR_CODE};
         do_cmd(OP_WRITE);
         send_frame(-1);
         wait_rsp(`PPFO_ST_OK, TO);
         check_got();
      end
   endtask

   task automatic s_timeout();
      for (int i = 0; i < 40; i++) fr[i] = 8'h41;
      stall = 1'b1;
      do_cmd(OP_WRITE);
      send_frame(10);
      wait_rsp(`PPFO_ST_BADFRM, 4);
      check_got();
      do_cmd(OP_WRITE);
      send_frame(-1);
      wait_rsp(`PPFO_ST_TIMEOUT, TO + 200);
      check({7'h0, prn.strobe_n}, 8'h01);
      e = '{8'h41};
      check_got();
      stall = 1'b0;
      repeat (20) @(negedge sys_clk);
      ppfo_printer_model_inst.got.delete();
      do_cmd(OP_STATUS);
      wait_rsp(`PPFO_ST_TIMEOUT, 1);
   endtask

   task automatic refuse(input ppfo_op_type op, input logic pres, input logic onl);
      prn_present = pres;
      prn_online  = onl;
      cmd.op      = op;
      cmd_valid   = 1'b1;
      repeat (5) begin
         @(negedge sys_clk);
         check({7'h0, cmd_ready}, 8'h00);
         check({7'h0, rsp_valid}, 8'h00);
      end
      cmd_valid   = 1'b0;
      prn_present = 1'b1;
      prn_online  = 1'b1;
      @(negedge sys_clk);
   endtask

   // plain status and an invalid command, each answered the next cycle
   task automatic s_cmds();
      do_cmd(OP_STATUS);
      wait_rsp(`PPFO_ST_OK, 1);
      do_cmd(OP_OTHER);
      wait_rsp(`PPFO_ST_BADCMD, 4);
   endtask

   // ----------------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // about 30k cycles of traffic; three times that before giving up
   initial begin
      #900_000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      s_cmds();
      s_full();
      s_eol();
      s_timeout();
      refuse(OP_STATUS, 1'b1, 1'b0);
      refuse(OP_WRITE, 1'b0, 1'b1);
      report_and_stop();
   end
endmodule
